// ==== design/asu_pkg.sv ====
// Package for the accumulator and stack unit
// Shared by the top module and its two helpers; no bus, no registers
package asu_pkg;
   localparam int                 ASU_ACC_W       = 32;
   localparam int                 ASU_WORD_W      = 16;
   localparam int                 ASU_DEPTH       = 8;
   localparam int                 ASU_LVL_W       = 3;
   localparam int                 ASU_OCT_DIGITS  = 6;
   localparam int                 ASU_SIGN_BIT    = 31;
   localparam logic [31:0]        ASU_ACC_RST     = 32'h0000_0000;
   localparam logic [15:0]        ASU_HALF_ZERO   = 16'h0000;
   localparam logic [3:0]         ASU_CNT_RST     = 4'h0;

   // Operation presented to the stack helper
   typedef enum logic [1:0] {ASU_STK_HOLD, ASU_STK_PUSH, ASU_STK_POP, ASU_STK_CLEAR} asu_stk_op_t;
endpackage

// ==== design/asu_oct2hex.sv ====
// Octal to binary address converter
// Operand holds one octal digit per nibble in its 16 bits
`timescale 1ns/10ps
module asu_oct2hex
   import asu_pkg::*;
(
   input  wire logic [15:0] oct_in,
   output logic      [15:0] hex_out
);
   // Each nibble keeps its low three bits as one octal digit
   always_comb
   begin
      hex_out = 16'h0000;
      for (int i = 0; i < 4; i++)
      begin
         hex_out = {hex_out[12:0], 3'b000} | {13'h0000, oct_in[4*(3-i) +: 3]};
      end
   end
endmodule

// ==== design/asu_stack.sv ====
// Eight level push-down stack of 32-bit words
// Driven by the top module; one operation per cycle
`timescale 1ns/10ps
module asu_stack
   import asu_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire asu_stk_op_t       op,
   input  wire logic [31:0]       push_data,
   output logic      [31:0]       top_data,
   output logic      [3:0]        depth_q
);
   logic [31:0] level_q [ASU_DEPTH];

   assign top_data = level_q[0];

   // Each level takes its upper neighbour on a push, its lower one on a pop
   genvar g;
   generate
      for (g = 0; g < ASU_DEPTH; g++)
      begin : g_lvl
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               level_q[g] <= ASU_ACC_RST;
            else
               case (op)
                  ASU_STK_PUSH:  level_q[g] <= (g == 0) ? push_data : level_q[(g == 0) ? 0 : g-1];
                  ASU_STK_POP:   level_q[g] <= (g == ASU_DEPTH-1) ? ASU_ACC_RST
                                               : level_q[(g == ASU_DEPTH-1) ? g : g+1];
                  ASU_STK_CLEAR: level_q[g] <= ASU_ACC_RST;
                  default:       level_q[g] <= level_q[g];
               endcase
         end
      end
   endgenerate

   // Count of occupied levels, saturating at eight
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         depth_q <= ASU_CNT_RST;
      else
         case (op)
            ASU_STK_PUSH:  if (depth_q != 4'(ASU_DEPTH)) depth_q <= depth_q + 4'h1;
            ASU_STK_POP:   if (depth_q != ASU_CNT_RST) depth_q <= depth_q - 4'h1;
            ASU_STK_CLEAR: depth_q <= ASU_CNT_RST;
            default:       depth_q <= depth_q;
         endcase
   end
endmodule

// ==== design/asu_top.sv ====
// Accumulator with eight level stack for the instruction executor
// Assumes one strobe at a time from the sequencer on the same clock
// Data memory sits outside; operands arrive on the same edge as the strobe
// Outputs are all registered; the stack helper holds the eight levels
// Functional notes
// - one 32-bit accumulator holds working data
// - scan end clears accumulator to zero
// - double load/store move two 16-bit words
// - manipulation result replaces prior accumulator value
// - first load of scan never pushes
// - later loads without store push first
// - store cancels the pending push
// - push moves every stack level down
// - stack has eight 32-bit levels
// - push discards eighth level value
// - pop drops accumulator, shifts stack up
// - pointer contents are hex word addresses
// - load address converts octal to hex
// - single load zeroes upper sixteen bits
// - negative flag follows accumulator sign
// - zero flag set when zero loaded
`timescale 1ns/10ps
module asu_top
   import asu_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,

   // Operation strobes, at most one per cycle
   input  wire logic        load_single_word,
   input  wire logic        load_double_word,
   input  wire logic        load_address_convert,
   input  wire logic        load_pointer,
   input  wire logic        manip_strobe,
   input  wire logic        store_strobe,
   input  wire logic        pop_strobe,
   input  wire logic        scan_end,

   // Operands that come with the strobes
   input  wire logic [15:0] mem_lo,
   input  wire logic [15:0] mem_hi,
   input  wire logic [31:0] manip_result,

   // Accumulator, store words and pointer
   output logic      [31:0] acc_q,
   output logic      [15:0] store_lo_q,
   output logic      [15:0] store_hi_q,
   output logic             store_valid_q,
   output logic      [15:0] pointer_addr_q,

   // Status flags and stack view
   output logic             accumulator_negative_flag,
   output logic             accumulator_zero_flag,
   output logic      [31:0] stack_top_q,
   output logic      [3:0]  stack_depth
);
   // Internal state and decoded operation
   logic              push_pending_q;
   logic              push_pending_d;
   logic              any_load;
   logic [15:0]       addr_hex;
   logic [31:0]       single_value;
   logic [31:0]       double_value;
   logic [31:0]       addr_value;
   logic [31:0]       load_value;
   logic [31:0]       acc_d;
   logic [31:0]       top_data;
   asu_stk_op_t       stk_op;

   // True when a 32-bit value is all zero; shared by the load and result paths of the zero flag
   function automatic logic acc_is_zero
   (
      input logic [31:0] value
   );
      return (value == ASU_ACC_RST);
   endfunction

   // Sign of a 32-bit value; a load, a result and a pop all use it
   function automatic logic acc_sign
   (
      input logic [31:0] value
   );
      return value[ASU_SIGN_BIT];
   endfunction

   // Any of the three loads that write the accumulator from memory
   assign any_load = load_single_word | load_double_word | load_address_convert;

   asu_oct2hex u_conv
   (
      .oct_in  (mem_lo),
      .hex_out (addr_hex)
   );

   // Operand as each kind of load presents it
   assign single_value = {ASU_HALF_ZERO, mem_lo};
   assign double_value = {mem_hi, mem_lo};
   assign addr_value   = {ASU_HALF_ZERO, addr_hex};

   // Value a load places into the accumulator
   always_comb
   begin
      if (load_double_word)
      begin
         load_value = double_value;
      end
      else if (load_address_convert)
      begin
         load_value = addr_value;
      end
      else
      begin
         load_value = single_value;
      end
   end

   // Stack operation chosen from the strobe this cycle
   always_comb
   begin
      if (scan_end)
      begin
         stk_op = ASU_STK_CLEAR;
      end
      else if (any_load && push_pending_q)
      begin
         stk_op = ASU_STK_PUSH;
      end
      else if (pop_strobe)
      begin
         stk_op = ASU_STK_POP;
      end
      else
      begin
         stk_op = ASU_STK_HOLD;
      end
   end

   asu_stack u_stack
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .op        (stk_op),
      .push_data (acc_q),
      .top_data  (top_data),
      .depth_q   (stack_depth)
   );

   // Push pending after a load, cancelled by a store or scan end
   always_comb
   begin
      push_pending_d = push_pending_q;
      if (scan_end || store_strobe)
      begin
         push_pending_d = 1'b0;
      end
      else if (any_load)
      begin
         push_pending_d = 1'b1;
      end
   end

   // Pending-push register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         push_pending_q <= 1'b0;
      end
      else
      begin
         push_pending_q <= push_pending_d;
      end
   end

   // Next accumulator value; the newest operation replaces the old one
   always_comb
   begin
      acc_d = acc_q;
      if (scan_end)
      begin
         acc_d = ASU_ACC_RST;
      end
      else if (any_load)
      begin
         acc_d = load_value;
      end
      else if (manip_strobe)
      begin
         acc_d = manip_result;
      end
      else if (pop_strobe)
      begin
         acc_d = top_data;
      end
   end

   // Accumulator register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_q <= ASU_ACC_RST;
      end
      else
      begin
         acc_q <= acc_d;
      end
   end

   // Store pulse, one cycle after the store strobe
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         store_valid_q <= 1'b0;
      end
      else
      begin
         store_valid_q <= store_strobe;
      end
   end

   // Store words towards data memory, both words on the same edge
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         store_lo_q <= ASU_HALF_ZERO;
         store_hi_q <= ASU_HALF_ZERO;
      end
      else if (store_strobe)
      begin
         store_lo_q <= acc_q[15:0];
         store_hi_q <= acc_q[31:16];
      end
   end

   // Pointer contents taken as hex word address as read
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pointer_addr_q <= ASU_HALF_ZERO;
      end
      else if (load_pointer)
      begin
         pointer_addr_q <= mem_lo;
      end
   end

   // Negative flag follows the sign of whatever enters the accumulator
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         accumulator_negative_flag <= 1'b0;
      end
      else if (scan_end)
      begin
         accumulator_negative_flag <= 1'b0;
      end
      else if (any_load)
      begin
         accumulator_negative_flag <= acc_sign(load_value);
      end
      else if (manip_strobe)
      begin
         accumulator_negative_flag <= acc_sign(manip_result);
      end
      else if (pop_strobe)
      begin
         accumulator_negative_flag <= acc_sign(top_data);
      end
   end

   // Zero flag set by loads and results of zero; a pop leaves it alone
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         accumulator_zero_flag <= 1'b0;
      end
      else if (scan_end)
      begin
         accumulator_zero_flag <= 1'b0;
      end
      else if (any_load)
      begin
         accumulator_zero_flag <= acc_is_zero(load_value);
      end
      else if (manip_strobe)
      begin
         accumulator_zero_flag <= acc_is_zero(manip_result);
      end
   end

   // Registered copy of the stack top for observation
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stack_top_q <= ASU_ACC_RST;
      end
      else
      begin
         stack_top_q <= top_data;
      end
   end
endmodule

// ==== dv/asu_top_sva.sv ====
// Port checker for the accumulator stack unit
// Bound to asu_top; sees its ports only, one clock domain
`timescale 1ns/10ps
module asu_top_sva
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        load_single_word,
   input wire logic        load_double_word,
   input wire logic        store_strobe,
   input wire logic        pop_strobe,
   input wire logic        scan_end,
   input wire logic [15:0] mem_lo,
   input wire logic [15:0] mem_hi,
   input wire logic [31:0] acc_q,
   input wire logic [15:0] store_lo_q,
   input wire logic [15:0] store_hi_q,
   input wire logic        store_valid_q,
   input wire logic        accumulator_negative_flag,
   input wire logic        accumulator_zero_flag,
   input wire logic [3:0]  stack_depth
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Two loads in a row, and a store followed by a load
   sequence s_ldld; load_single_word ##1 load_single_word; endsequence
   sequence s_stld; store_strobe ##1 load_single_word; endsequence
   property p_ld; load_single_word |=> acc_q == {16'h0000, $past(mem_lo)}; endproperty
   property p_ldd; load_double_word |=> acc_q == {$past(mem_hi), $past(mem_lo)}; endproperty
   property p_st;
      store_strobe |=> store_valid_q && {store_hi_q, store_lo_q} == $past(acc_q);
   endproperty
   property p_clr; scan_end |=> acc_q == 32'h0000_0000 && stack_depth == 4'h0; endproperty
   property p_neg; accumulator_negative_flag == acc_q[31]; endproperty
   property p_push;
      s_ldld |=> stack_depth == (($past(stack_depth) == 4'h8) ? 4'h8 : $past(stack_depth) + 4'h1);
   endproperty
   property p_cancel; s_stld |=> $stable(stack_depth); endproperty
   property p_pop;
      pop_strobe |=> stack_depth == (($past(stack_depth) == 4'h0) ? 4'h0 : $past(stack_depth) - 4'h1);
   endproperty
   property p_zero;
      (load_double_word && mem_hi == 16'h0000 && mem_lo == 16'h0000) |=> accumulator_zero_flag;
   endproperty
   a_ld: assert property (p_ld) else $error("single load value wrong");
   a_ldd: assert property (p_ldd) else $error("double load value wrong");
   a_st: assert property (p_st) else $error("store words wrong");
   a_clr: assert property (p_clr) else $error("scan end left state");
   a_neg: assert property (p_neg) else $error("negative flag wrong");
   a_push: assert property (p_push) else $error("push depth wrong");
   a_cancel: assert property (p_cancel) else $error("push after store");
   a_pop: assert property (p_pop) else $error("pop depth wrong");
   a_zero: assert property (p_zero) else $error("zero flag missing");
endmodule
bind asu_top asu_top_sva u_sva (.clk(clk), .reset_n(reset_n),
   .load_single_word(load_single_word), .load_double_word(load_double_word),
   .store_strobe(store_strobe), .pop_strobe(pop_strobe), .scan_end(scan_end),
   .mem_lo(mem_lo), .mem_hi(mem_hi), .acc_q(acc_q), .store_lo_q(store_lo_q),
   .store_hi_q(store_hi_q), .store_valid_q(store_valid_q),
   .accumulator_negative_flag(accumulator_negative_flag),
   .accumulator_zero_flag(accumulator_zero_flag), .stack_depth(stack_depth));

// ==== dv/asu_seq_model.sv ====
// Instruction sequencer model: one strobe per cycle with its operands
// Called from the bench; changes its outputs at the falling edge
`timescale 1ns/10ps
module asu_seq_model
(
   input  wire logic        clk,
   output logic      [7:0]  stb,
   output logic      [15:0] mem_lo,
   output logic      [15:0] mem_hi,
   output logic      [31:0] manip_result
);
   // Quiet lines at time zero
   initial
   begin
      stb = 8'h00;
      mem_lo = 16'h0000;
      mem_hi = 16'h0000;
      manip_result = 32'h0000_0000;
   end
   // One-hot strobe; an idle cycle scrambles the released operands
   task automatic issue(input int k, input logic [15:0] lo, input logic [15:0] hi,
                        input logic [31:0] res);
      @(negedge clk);
      stb = (k == 0) ? 8'h00 : 8'(1 << (k - 1));
      mem_lo = (k == 0) ? ~mem_lo : lo;
      mem_hi = (k == 0) ? ~mem_hi : hi;
      manip_result = (k == 0) ? ~manip_result : res;
   endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the accumulator stack unit
// Needs the design, the sequencer model and the checker compiled first
`timescale 1ns/10ps
module testbench;
   logic             clk = 1'b0;
   logic             reset_n = 1'b0;
   logic             act, st_v, neg, zero, pend = 1'b0, zf = 1'b0;
   logic [7:0]       stb;
   logic [15:0]      mem_lo, mem_hi, st_lo, st_hi, ptr;
   logic [31:0]      res, acc_q, top, acc = 32'h0000_0000;
   logic [7:0][31:0] stk = '0;
   logic [3:0]       depth;
   logic [37:0]      aq[$];
   logic [31:0]      sq[$];
   logic [31:0]      tq[$];
   int               dep = 0, error_cnt = 0, compares = 0, seed = 32'h97b9, k;
   int               ops[8] = '{1, 2, 5, 6, 7, 8, 1, 7};
   asu_seq_model u_seq (.clk(clk), .stb(stb), .mem_lo(mem_lo), .mem_hi(mem_hi),
      .manip_result(res));
   asu_top u_dut (.clk(clk), .reset_n(reset_n), .load_single_word(stb[0]),
      .load_double_word(stb[1]), .load_address_convert(stb[2]), .load_pointer(stb[3]),
      .manip_strobe(stb[4]), .store_strobe(stb[5]), .pop_strobe(stb[6]), .scan_end(stb[7]),
      .mem_lo(mem_lo), .mem_hi(mem_hi), .manip_result(res), .acc_q(acc_q),
      .store_lo_q(st_lo), .store_hi_q(st_hi), .store_valid_q(st_v), .pointer_addr_q(ptr),
      .accumulator_negative_flag(neg), .accumulator_zero_flag(zero), .stack_top_q(top),
      .stack_depth(depth));
   always #2.5 clk = ~clk;
   task automatic note(input bit ok, input logic [37:0] e, input logic [37:0] g);
      compares++;
      if (!ok)
      begin
         error_cnt++;
         $display("BAD %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_acc(input logic [37:0] e, input logic [37:0] g);
      note(g === e, e, g);
   endtask
   task automatic chk_st(input logic [31:0] e, input logic [31:0] g);
      note(g === e, {6'h00, e}, {6'h00, g});
   endtask
   task automatic chk_top(input logic [31:0] e, input logic [31:0] g);
      note(g === e, {6'h00, e}, {6'h00, g});
   endtask
   task automatic chk_ptr(input logic [15:0] e, input logic [15:0] g);
      note(g === e, {22'h00_0000, e}, {22'h00_0000, g});
   endtask
   task automatic close_out();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Issue one operation and note what the unit should then hold
   task automatic op(input int c, input logic [15:0] lo, input logic [15:0] hi,
                     input logic [31:0] r);
      u_seq.issue(c, lo, hi, r);
      if (c != 0) tq.push_back(stk[0]); // Stack top as it stands before this op
      if (c inside {1, 2, 3} && pend)
      begin
         stk = {stk[6:0], acc};
         dep = (dep < 8) ? dep + 1 : 8;
      end
      case (c)
         1: acc = {16'h0000, lo};
         2: acc = {hi, lo};
         3: acc = {20'h0_0000, lo[14:12], lo[10:8], lo[6:4], lo[2:0]};
         5: acc = r;
         6: sq.push_back(acc);
         7:
         begin
            acc = stk[0];
            stk = {32'h0000_0000, stk[7:1]};
            dep = (dep > 0) ? dep - 1 : 0;
         end
         8:
         begin
            acc = 32'h0000_0000;
            stk = '0;
            dep = 0;
         end
         default:;
      endcase
      pend = (c inside {1, 2, 3}) ? 1'b1 : (c inside {6, 8}) ? 1'b0 : pend;
      zf = (c inside {1, 2, 3, 5}) ? (acc == 32'h0000_0000) : (c == 8) ? 1'b0 : zf;
      if (c != 0) aq.push_back({acc, 4'(dep), acc[31], zf});
   endtask
   // Compare each result against the oldest note
   always @(posedge clk)
   begin
      act = |stb;
      #1;
      if (act) chk_acc(aq.pop_front(), {acc_q, depth, neg, zero});
      if (act) chk_top(tq.pop_front(), top);
      if (st_v === 1'b1) chk_st(sq.pop_front(), {st_hi, st_lo});
   end
   // Directed corner cases, then random traffic
   initial
   begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      for (int i = 0; i < 10; i++) op(1, 16'(i + 1), 16'h0000, 32'h0000_0000);
      op(6, 16'h0000, 16'h0000, 32'h0000_0000);
      op(1, 16'hbeef, 16'h0000, 32'h0000_0000);
      op(2, 16'h0000, 16'h8000, 32'h0000_0000);
      op(5, 16'h0000, 16'h0000, 32'h0000_0000);
      for (int i = 0; i < 10; i++) op(7, 16'h0000, 16'h0000, 32'h0000_0000);
      op(8, 16'h0000, 16'h0000, 32'h0000_0000);
      op(3, 16'h7654, 16'h0000, 32'h0000_0000);
      op(6, 16'h0000, 16'h0000, 32'h0000_0000);
      op(4, 16'h1234, 16'h0000, 32'h0000_0000);
      op(6, 16'h0000, 16'h0000, 32'h0000_0000);
      chk_ptr(16'h1234, ptr);
      op(2, 16'h0000, 16'h0000, 32'h0000_0000);
      for (int i = 0; i < 300; i++)
      begin
         k = ops[$unsigned($random(seed)) % 8];
         op(k, 16'($random(seed)), 16'($random(seed)), $random(seed));
      end
      op(0, 16'h0000, 16'h0000, 32'h0000_0000);
      op(0, 16'h0000, 16'h0000, 32'h0000_0000);
      close_out();
   end
   // Watchdog well past the expected run length
   initial
   begin
      #(5 * 4000);
      error_cnt++;
      close_out();
   end
endmodule
